//--- bench/lbt_ctrl_model.sv
// disk controller model that issues return-to-zero command pulses
`timescale 1ns/1ps
module lbt_ctrl_model (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic issue, // bench asks for one command
	input wire logic seek_error, // positioning error line
	input wire logic seek_end, // positioning done line
	output logic rtz_cmd // one-cycle command pulse
);
////////////////////////////////////////////////////////////////////////
	// command after failure
	// one pulse per request, never stretched, so a standing error is cleared only when asked
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rtz_cmd <= 1'b0;
		else
			rtz_cmd <= issue & !rtz_cmd;
	end
endmodule : lbt_ctrl_model

//--- bench/lbt_seq_test.sv
// self-checking bench of the backup and turnaround sequencer
`timescale 1ns/1ps
`include "lbt_defines.svh"
module lbt_seq_test;
	logic aclk, aresetn = 1'b0, backup_start = 1'b0, fault_clear = 1'b0, overspeed = 1'b0;
	logic guardband = 1'b0, cyl_pulse = 1'b0, demod_ok = 1'b1, issue = 1'b0, rtz_cmd;
	logic [7:0] status_code;
	logic reverse_dir, forward_dir, servo_enable, heads_unload, initial_load_lamp, fault_lamp;
	logic drive_trouble, seek_error, seek_end, load_request, seq_done, irq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int err_count = 0, checked = 0, cycles = 0, lr_cnt = 0, sd_cnt = 0;
////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// short timeouts keep every phase to twenty cycles
	lbt_seq #(.BACKUP_CYC(20), .GUARD_CYC(20), .TRACK_CYC(20)) i_lbt_seq (.aclk(aclk), .aresetn(aresetn),
		.backup_start(backup_start), .rtz_cmd(rtz_cmd), .fault_clear(fault_clear), .overspeed(overspeed),
		.guardband(guardband), .cyl_pulse(cyl_pulse), .demod_ok(demod_ok), .status_code(status_code),
		.reverse_dir(reverse_dir), .forward_dir(forward_dir), .servo_enable(servo_enable),
		.heads_unload(heads_unload), .initial_load_lamp(initial_load_lamp), .fault_lamp(fault_lamp),
		.drive_trouble(drive_trouble), .seek_error(seek_error), .seek_end(seek_end),
		.load_request(load_request), .seq_done(seq_done), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	lbt_ctrl_model i_lbt_ctrl_model (.aclk(aclk), .aresetn(aresetn), .issue(issue),
		.seek_error(seek_error), .seek_end(seek_end), .rtz_cmd(rtz_cmd));
////////////////////////////////////////////////////////////////////////
	// pulse counters and the hang limit; a hang ends in the same report
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (load_request === 1'b1) lr_cnt <= lr_cnt + 1;
		if (seq_done === 1'b1) sd_cnt <= sd_cnt + 1;
		if (cycles == 5000)
		begin
			err_count = err_count + 1;
			final_report();
		end
	end
	task final_report;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// waits end 1 ns past the edge so registered outputs have landed
	task cyc(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : cyc
	task edges(input int n);
		repeat (n)
		begin
			@(posedge aclk) cyl_pulse <= 1'b1;
			@(posedge aclk) cyl_pulse <= 1'b0;
		end
	endtask : edges
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task pulse_cmd;
		@(posedge aclk) issue <= 1'b1;
		@(posedge aclk) issue <= 1'b0;
	endtask : pulse_cmd
	// one return-to-zero attempt driven into an error; servo stays on exactly when heads unload
	task run_err(input logic gb0, input logic ovs, input int g, input int t, input logic gd, input logic dd,
		input logic [7:0] code, input logic unl);
		@(posedge aclk);
		guardband <= gb0;
		overspeed <= ovs;
		pulse_cmd();
		cyc(3);
		edges(g);
		cyc(3);
		edges(t);
		@(posedge aclk);
		if (gd) guardband <= 1'b0;
		if (dd) demod_ok <= 1'b0;
		while (seek_error !== 1'b1) @(posedge aclk);
		#1;
		cmp({status_code, seek_error, seek_end, drive_trouble, heads_unload, servo_enable}, {code, 3'b110, unl, unl});
		@(posedge aclk);
		overspeed <= 1'b0;
		demod_ok <= 1'b1;
		guardband <= 1'b1;
	endtask : run_err
	// new command after an error, then a full clean pass of cylinder pulses
	task recover(input logic via_reg, input int lr, input int sd);
		int l0;
		int s0;
		l0 = lr_cnt;
		s0 = sd_cnt;
		if (via_reg) axi_wr(8'h10, 32'h1);
		else pulse_cmd();
		cyc(3);
		edges(6);
		cyc(3);
		edges(4);
		cyc(3);
		edges(1);
		cyc(3);
		cmp({seek_error, seek_end, status_code}, 32'h0);
		cmp(lr_cnt - l0, lr);
		cmp(sd_cnt - s0, sd);
	endtask : recover
////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(1);
		cmp({status_code, servo_enable, irq}, 32'h2);
		axi_rd(8'h00);
		cmp(rd[16:0], 32'h10000);
		axi_rd(8'h40);
		cmp(r, `LBT_RESP_SLVERR);
		cmp(rd, 32'h0);
		axi_wr(8'h40, 32'h0);
		cmp(r, `LBT_RESP_SLVERR);
		axi_wr(8'h0c, 32'h7);
		cmp(r, `LBT_RESP_OKAY);
		axi_rd(8'h0c);
		cmp(rd, 32'h7);
		$display("register test done");
		@(posedge aclk) overspeed <= 1'b1;
		@(posedge aclk) backup_start <= 1'b1;
		@(posedge aclk) backup_start <= 1'b0;
		cyc(4);
		cmp({status_code, initial_load_lamp, fault_lamp, drive_trouble, heads_unload, seek_error, seek_end,
			servo_enable, irq}, {8'h32, 8'b11110011});
		@(posedge aclk) overspeed <= 1'b0;
		pulse_cmd();
		cyc(3);
		cmp(status_code, 8'h32);
		@(posedge aclk) fault_clear <= 1'b1;
		@(posedge aclk) fault_clear <= 1'b0;
		cyc(3);
		cmp({status_code, initial_load_lamp, fault_lamp, drive_trouble, lr_cnt[7:0]}, 32'h1);
		// a first-seek guardband error still unloads; the register path clears it
		@(posedge aclk) guardband <= 1'b1;
		@(posedge aclk) backup_start <= 1'b1;
		@(posedge aclk) backup_start <= 1'b0;
		@(posedge aclk) demod_ok <= 1'b0;
		cyc(3);
		cmp({status_code, initial_load_lamp, drive_trouble, heads_unload, servo_enable, seek_error},
			{8'h34, 5'b11110});
		@(posedge aclk) demod_ok <= 1'b1;
		axi_wr(8'h10, 32'h2);
		cyc(2);
		cmp({status_code, initial_load_lamp, lr_cnt[7:0]}, 32'h2);
		@(posedge aclk) guardband <= 1'b1;
		@(posedge aclk) backup_start <= 1'b1;
		@(posedge aclk) backup_start <= 1'b0;
		cyc(4);
		cmp({status_code, reverse_dir, forward_dir}, {8'h34, 2'b10});
		edges(5);
		cyc(3);
		cmp(status_code, 8'h34);
		edges(1);
		cyc(3);
		cmp({status_code, reverse_dir, forward_dir}, {8'h35, 2'b01});
		edges(3);
		cyc(3);
		cmp(status_code, 8'h35);
		edges(1);
		cyc(3);
		cmp(status_code, 8'h37);
		edges(1);
		cyc(3);
		cmp({status_code, sd_cnt[7:0]}, 32'h1);
		axi_rd(8'h00);
		cmp(rd[16], 1'b0);
		$display("first seek test done");
		axi_wr(8'h08, 32'h7);
		run_err(1'b0, 1'b1, 0, 0, 1'b0, 1'b0, 8'h32, 1'b1);
		axi_rd(8'h04);
		cmp({rd[2:0], irq}, 4'hb);
		axi_wr(8'h0c, 32'h0);
		cyc(1);
		cmp(irq, 1'b0);
		axi_wr(8'h0c, 32'h7);
		axi_wr(8'h08, 32'h7);
		cyc(1);
		cmp(irq, 1'b0);
		recover(1'b0, 1, 0);
		run_err(1'b0, 1'b0, 0, 0, 1'b0, 1'b0, 8'h33, 1'b1);
		recover(1'b1, 1, 0);
		run_err(1'b1, 1'b0, 2, 0, 1'b0, 1'b1, 8'h34, 1'b0);
		recover(1'b0, 1, 0);
		run_err(1'b1, 1'b0, 6, 0, 1'b0, 1'b0, 8'h35, 1'b0);
		recover(1'b0, 1, 0);
		run_err(1'b1, 1'b0, 6, 2, 1'b1, 1'b0, 8'h36, 1'b0);
		recover(1'b0, 0, 1);
		run_err(1'b1, 1'b0, 6, 4, 1'b0, 1'b1, 8'h37, 1'b1);
		recover(1'b0, 0, 1);
		run_err(1'b1, 1'b0, 6, 4, 1'b0, 1'b0, 8'h37, 1'b0);
		recover(1'b0, 0, 1);
		$display("return to zero test done");
		final_report();
	end
endmodule : lbt_seq_test

//--- verilog/lbt_defines.svh
// constants of the backup and turnaround sequencer
`ifndef LBT_DEFINES_SVH
`define LBT_DEFINES_SVH
`define LBT_CLK_PERIOD_NS 10
`define LBT_CYC_PER_US (1000 / `LBT_CLK_PERIOD_NS)
`define LBT_BACKUP_TMO_US 2000
`define LBT_GUARD_TMO_US 1000
`define LBT_TRACK_TMO_US 1000
`define LBT_CODE_NONE 8'h00
`define LBT_CODE_32 8'h32
`define LBT_CODE_33 8'h33
`define LBT_CODE_34 8'h34
`define LBT_CODE_35 8'h35
`define LBT_CODE_36 8'h36
`define LBT_CODE_37 8'h37
`define LBT_GUARD_PULSES 4'h6
`define LBT_FWD_PULSES 4'h4
`define LBT_REG_STATUS 6'h00
`define LBT_REG_IRQ_STAT 6'h01
`define LBT_REG_IRQ_CLR 6'h02
`define LBT_REG_IRQ_EN 6'h03
`define LBT_REG_CTRL 6'h04
`define LBT_CTRL_RTZ 0
`define LBT_CTRL_CLEAR 1
`define LBT_IRQ_ERROR 0
`define LBT_IRQ_DONE 1
`define LBT_IRQ_RETRY 2
`define LBT_IRQ_W 3
`define LBT_RESP_OKAY 2'h0
`define LBT_RESP_SLVERR 2'h2
`endif

//--- verilog/lbt_pkg.sv
// types of the backup and turnaround sequencer
package lbt_pkg;
	typedef enum logic [2:0] {S_IDLE, S_BACKUP, S_GUARD, S_TURN, S_TRACK, S_ERROR} lbt_state_t;
endpackage : lbt_pkg

//--- verilog/lbt_seq.sv
// backup and turnaround sequencer with its register slave
`timescale 1ns/1ps
`include "lbt_defines.svh"
module lbt_seq #(
	parameter int TW = 20,
	parameter int BACKUP_CYC = `LBT_BACKUP_TMO_US * `LBT_CYC_PER_US,
	parameter int GUARD_CYC = `LBT_GUARD_TMO_US * `LBT_CYC_PER_US,
	parameter int TRACK_CYC = `LBT_TRACK_TMO_US * `LBT_CYC_PER_US
) (
	input wire logic aclk, // 100 MHz clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic backup_start, // load sequence enters backup
	input wire logic rtz_cmd, // return_to_cylinder_zero pulse
	input wire logic fault_clear, // operator fault-clear button
	input wire logic overspeed, // head velocity too high
	input wire logic guardband, // outer guardband seen
	input wire logic cyl_pulse, // servo cylinder pulse
	input wire logic demod_ok, // demodulator valid
	output logic [7:0] status_code, // two hex digit status
	output logic reverse_dir, // reverse direction command
	output logic forward_dir, // forward direction command
	output logic servo_enable, // servo loop enabled
	output logic heads_unload, // retract heads
	output logic initial_load_lamp, // first-seek error lamp
	output logic fault_lamp, // fault indicator
	output logic drive_trouble, // fault line to controller
	output logic seek_error, // positioning error line
	output logic seek_end, // positioning done line
	output logic load_request, // pulse: start a fresh load
	output logic seq_done, // pulse: track -1 reached
	output logic irq, // level interrupt
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	if (TW < 2 || BACKUP_CYC < 1 || GUARD_CYC < 1 || TRACK_CYC < 1 ||
		BACKUP_CYC >= 2**TW || GUARD_CYC >= 2**TW || TRACK_CYC >= 2**TW)
	begin : g_chk
		$error("lbt_seq: timeout counts do not fit the timer");
	end

	////////////////////////////////////////////////////////////////////////////
	// state
	lbt_pkg::lbt_state_t state_reg, state_next;
	logic [7:0] code_reg, code_next;
	logic [3:0] cnt_reg, cnt_next;
	logic first_reg, first_next;
	logic rtz_reg, rtz_next;
	logic retry_reg, retry_next;
	logic unload_reg, unload_next;
	logic float_reg, float_next;
	logic rev_reg, fwd_reg;
	logic ldreq_reg, ldreq_next, done_reg, done_next, rty_ev;
	logic cyl_prev_reg;
	logic tload;
	logic [TW-1:0] tval;
	logic texp;
	logic raise, raise_unload;
	logic [7:0] raise_code;
	logic sw_rtz, sw_clr;

	wire cyl_edge = cyl_pulse & ~cyl_prev_reg;
	wire rtz_req = rtz_cmd | sw_rtz;
	wire clear_req = fault_clear | sw_clr;
	wire in_err = (state_reg == lbt_pkg::S_ERROR);
	// codes 32..35 restart the whole load, 36/37 only reseek
	wire code_reload = (code_reg >= `LBT_CODE_32) && (code_reg <= `LBT_CODE_35);

	lbt_timer #(.W(TW)) u_tmr (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tload),
		.load_val(tval),
		.expired(texp)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb
	begin
		state_next = state_reg;
		code_next = code_reg;
		cnt_next = cnt_reg;
		first_next = first_reg;
		rtz_next = rtz_reg;
		retry_next = retry_reg;
		unload_next = unload_reg;
		float_next = float_reg;
		ldreq_next = 1'b0;
		done_next = 1'b0;
		rty_ev = 1'b0;
		tload = 1'b0;
		tval = TW'(BACKUP_CYC);
		raise = 1'b0;
		raise_unload = 1'b0;
		raise_code = `LBT_CODE_NONE;
		unique case (state_reg)
			lbt_pkg::S_IDLE:
			begin
				// a command during the first seek waits for the load itself
				if (backup_start || (rtz_req && !first_reg))
				begin
					state_next = lbt_pkg::S_BACKUP;
					code_next = `LBT_CODE_NONE;
					rtz_next = !backup_start;
					retry_next = 1'b0;
					tload = 1'b1;
				end
			end
			lbt_pkg::S_BACKUP:
			begin
				if (overspeed)
				begin
					raise = 1'b1;
					raise_unload = 1'b1;
					raise_code = `LBT_CODE_32;
				end
				else if (texp)
				begin
					raise = 1'b1;
					raise_unload = 1'b1;
					raise_code = `LBT_CODE_33;
				end
				else if (guardband)
				begin
					state_next = lbt_pkg::S_GUARD;
					code_next = `LBT_CODE_34;
					cnt_next = 4'h0;
					tval = TW'(GUARD_CYC);
					tload = 1'b1;
				end
			end
			lbt_pkg::S_GUARD:
			begin
				if (!demod_ok || texp)
				begin
					raise = 1'b1;
					raise_code = `LBT_CODE_34;
				end
				else if (cyl_edge)
				begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == `LBT_GUARD_PULSES - 4'h1)
					begin
						state_next = lbt_pkg::S_TURN;
						code_next = `LBT_CODE_35;
						cnt_next = 4'h0;
						tval = TW'(GUARD_CYC);
						tload = 1'b1;
					end
				end
			end
			lbt_pkg::S_TURN:
			begin
				if (!demod_ok || texp)
				begin
					raise = 1'b1;
					raise_code = `LBT_CODE_35;
				end
				else if (cyl_edge)
				begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == `LBT_FWD_PULSES - 4'h1)
					begin
						state_next = lbt_pkg::S_TRACK;
						code_next = `LBT_CODE_37;
						tval = TW'(TRACK_CYC);
						tload = 1'b1;
					end
				end
				else if (!guardband)
				begin
					raise = 1'b1;
					raise_code = `LBT_CODE_36;
				end
			end
			lbt_pkg::S_TRACK:
			begin
				if (!demod_ok || texp)
				begin
					raise = 1'b1;
					raise_unload = !demod_ok;
					raise_code = `LBT_CODE_37;
				end
				else if (cyl_edge)
				begin
					state_next = lbt_pkg::S_IDLE;
					code_next = `LBT_CODE_NONE;
					first_next = 1'b0;
					done_next = 1'b1;
				end
			end
			lbt_pkg::S_ERROR:
			begin
				if (first_reg && clear_req)
				begin
					state_next = lbt_pkg::S_IDLE;
					code_next = `LBT_CODE_NONE;
					ldreq_next = 1'b1;
					unload_next = 1'b0;
					float_next = 1'b0;
				end
				else if (!first_reg && rtz_req && code_reload)
				begin
					state_next = lbt_pkg::S_IDLE;
					code_next = `LBT_CODE_NONE;
					ldreq_next = 1'b1;
					unload_next = 1'b0;
					float_next = 1'b0;
				end
				else if (!first_reg && rtz_req)
				begin
					state_next = lbt_pkg::S_BACKUP;
					code_next = `LBT_CODE_NONE;
					rtz_next = 1'b1;
					retry_next = 1'b0;
					unload_next = 1'b0;
					float_next = 1'b0;
					tload = 1'b1;
				end
			end
		endcase
		if (raise)
		begin
			code_next = raise_code;
			if (rtz_reg && !first_reg && !retry_reg && raise_unload && state_reg == lbt_pkg::S_BACKUP)
			begin
				state_next = lbt_pkg::S_BACKUP;
				retry_next = 1'b1;
				rty_ev = 1'b1;
				tload = 1'b1;
			end
			else
			begin
				state_next = lbt_pkg::S_ERROR;
				unload_next = raise_unload || first_reg;
				float_next = !(raise_unload || first_reg);
			end
		end
	end

	// code held till recovery
	// the code register keeps an error until its recovery path runs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= lbt_pkg::S_IDLE;
			code_reg <= `LBT_CODE_NONE;
			cnt_reg <= 4'h0;
			first_reg <= 1'b1;
			rtz_reg <= 1'b0;
			retry_reg <= 1'b0;
			unload_reg <= 1'b0;
			float_reg <= 1'b0;
			ldreq_reg <= 1'b0;
			done_reg <= 1'b0;
			cyl_prev_reg <= 1'b0;
			rev_reg <= 1'b0;
			fwd_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			code_reg <= code_next;
			cnt_reg <= cnt_next;
			first_reg <= first_next;
			rtz_reg <= rtz_next;
			retry_reg <= retry_next;
			unload_reg <= unload_next;
			float_reg <= float_next;
			ldreq_reg <= ldreq_next;
			done_reg <= done_next;
			cyl_prev_reg <= cyl_pulse;
			rev_reg <= (state_next == lbt_pkg::S_BACKUP) || (state_next == lbt_pkg::S_GUARD);
			fwd_reg <= (state_next == lbt_pkg::S_TURN) || (state_next == lbt_pkg::S_TRACK);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// indications; sets both lines outside the first seek
	assign status_code = code_reg;
	assign reverse_dir = rev_reg;
	assign forward_dir = fwd_reg;
	assign servo_enable = !float_reg;
	assign heads_unload = unload_reg;
	assign initial_load_lamp = in_err && first_reg;
	assign fault_lamp = in_err && first_reg;
	assign drive_trouble = in_err && first_reg;
	assign seek_error = in_err && !first_reg;
	assign seek_end = in_err && !first_reg;
	assign load_request = ldreq_reg;
	assign seq_done = done_reg;

	////////////////////////////////////////////////////////////////////////////
	// interrupts: status sets win over a clear in the same cycle
	logic [`LBT_IRQ_W-1:0] ist_reg, ien_reg;
	logic [`LBT_IRQ_W-1:0] iev;
	logic wr_go, rd_go;
	wire [5:0] waddr = s_axi_awaddr[7:2];
	wire [5:0] raddr = s_axi_araddr[7:2];
	wire wr_lane0 = wr_go && s_axi_wstrb[0];
	wire [`LBT_IRQ_W-1:0] iclr = (wr_lane0 && waddr == `LBT_REG_IRQ_CLR) ? s_axi_wdata[`LBT_IRQ_W-1:0] : '0;
	assign iev[`LBT_IRQ_ERROR] = (state_next == lbt_pkg::S_ERROR) && !in_err;
	assign iev[`LBT_IRQ_DONE] = done_next;
	assign iev[`LBT_IRQ_RETRY] = rty_ev;
	assign irq = |(ist_reg & ien_reg);
	assign sw_rtz = wr_lane0 && (waddr == `LBT_REG_CTRL) && s_axi_wdata[`LBT_CTRL_RTZ];
	assign sw_clr = wr_lane0 && (waddr == `LBT_REG_CTRL) && s_axi_wdata[`LBT_CTRL_CLEAR];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ist_reg <= '0;
			ien_reg <= '0;
		end
		else
		begin
			ist_reg <= (ist_reg & ~iclr) | iev;
			if (wr_lane0 && waddr == `LBT_REG_IRQ_EN)
				ien_reg <= s_axi_wdata[`LBT_IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register slave: write taken when address and data both present
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	wire wmap = (waddr <= `LBT_REG_CTRL);
	wire rmap = (raddr <= `LBT_REG_CTRL);
	wire [31:0] rsel = (raddr == `LBT_REG_STATUS) ?
		{13'h0000, retry_reg, rtz_reg, first_reg, 5'h00, state_reg, code_reg} :
		(raddr == `LBT_REG_IRQ_STAT) ? {29'h00000000, ist_reg} :
		(raddr == `LBT_REG_IRQ_EN) ? {29'h00000000, ien_reg} : 32'h00000000;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_go = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `LBT_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `LBT_RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			if (wr_go)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wmap ? `LBT_RESP_OKAY : `LBT_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (rd_go)
			begin
				rvalid_reg <= 1'b1;
				rresp_reg <= rmap ? `LBT_RESP_OKAY : `LBT_RESP_SLVERR;
				rdata_reg <= rmap ? rsel : 32'h00000000;
			end
			else if (s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_turn_entry;
		state_reg == lbt_pkg::S_GUARD && demod_ok && !texp && cyl_edge && cnt_reg == `LBT_GUARD_PULSES - 4'h1;
	endsequence
	sequence s_retry_cause;
		state_reg == lbt_pkg::S_BACKUP && rtz_reg && !first_reg && !retry_reg && (overspeed || texp);
	endsequence

	AST_OVERSPEED: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == lbt_pkg::S_BACKUP && overspeed |=> code_reg == `LBT_CODE_32)
		else $error("overspeed did not give code 32");
	AST_BACKUP_TMO: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == lbt_pkg::S_BACKUP && !overspeed && texp |=> code_reg == `LBT_CODE_33)
		else $error("backup timeout did not give code 33");
	AST_TURN: assert property (@(posedge aclk) disable iff (!aresetn)
		s_turn_entry |=> code_reg == `LBT_CODE_35 && fwd_reg && !rev_reg ##1 (fwd_reg || in_err))
		else $error("turnaround code or direction wrong");
	AST_GUARD_DEMOD: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == lbt_pkg::S_GUARD && !demod_ok |=> in_err && code_reg == `LBT_CODE_34)
		else $error("demod loss in guardband not an error");
	AST_FIRST_IND: assert property (@(posedge aclk) disable iff (!aresetn)
		in_err && first_reg |-> initial_load_lamp && drive_trouble && heads_unload && !seek_error)
		else $error("first seek error indications wrong");
	AST_SEEK_IND: assert property (@(posedge aclk) disable iff (!aresetn)
		in_err && !first_reg |-> seek_error && seek_end && !drive_trouble)
		else $error("positioning error lines wrong");
	AST_RETRY: assert property (@(posedge aclk) disable iff (!aresetn)
		s_retry_cause |=> state_reg == lbt_pkg::S_BACKUP && retry_reg && !in_err)
		else $error("automatic retry not taken");
	AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		in_err && first_reg && clear_req |=> load_request && state_reg == lbt_pkg::S_IDLE ##1 !load_request)
		else $error("fault clear did not restart load");
	AST_FLOAT: assert property (@(posedge aclk) disable iff (!aresetn)
		in_err && !first_reg && code_reg >= `LBT_CODE_34 && code_reg <= `LBT_CODE_36 |-> !servo_enable && !heads_unload)
		else $error("guardband error did not float heads");
	AST_TRACK_UNLOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		state_reg == lbt_pkg::S_TRACK && !demod_ok |=> heads_unload && code_reg == `LBT_CODE_37)
		else $error("demod loss at track -1 did not unload");
	AST_RESEEK: assert property (@(posedge aclk) disable iff (!aresetn)
		in_err && !first_reg && rtz_req && code_reg >= `LBT_CODE_36 |=> state_reg == lbt_pkg::S_BACKUP && !load_request)
		else $error("return-to-zero did not reseek");
endmodule : lbt_seq

//--- verilog/lbt_timer.sv
// phase timeout down-counter
`timescale 1ns/1ps
module lbt_timer #(
	parameter int W = 20
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic load, // restart the count
	input wire logic [W-1:0] load_val, // cycles until expiry
	output logic expired // high once the count is spent
);
	logic [W-1:0] cnt_reg;
	// zero after reset reads as expired; every timed phase loads on entry
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_reg <= '0;
		else if (load)
			cnt_reg <= load_val;
		else if (cnt_reg != '0)
			cnt_reg <= cnt_reg - 1'b1;
	end
	assign expired = (cnt_reg == '0);
endmodule : lbt_timer
